// file: src/wiper_map.vh
`ifndef WIPER_MAP_VH
`define WIPER_MAP_VH

// ==========================================================
// Register offsets (APB byte addresses)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C

// ==========================================================
// Field positions and reset values
`define CTRL_ENABLE     0
`define CTRL_RESET      1'b1
`define IRQ_WIPE        0
`define IRQ_FAULT       1
`define IRQ_IGN_ON      2
`define IRQ_W           3
`define MASK_RESET      3'h0

// ==========================================================
// Stalk selections over LIN
`define SEL_OFF         3'h0
`define SEL_MIST        3'h1
`define SEL_LOW         3'h2
`define SEL_HIGH        3'h3
`define SEL_AUTO        3'h4

// ==========================================================
// Rain sensor codes decoded from the duty cycle
`define CODE_OFF        3'h0
`define CODE_RAIN_INT   3'h1
`define CODE_RAIN_LOW   3'h2
`define CODE_RAIN_HIGH  3'h3
`define CODE_FAULT1     3'h4
`define CODE_NONE       3'h7
// Upper band edges in percent of the frame
`define DUTY_OFF_MAX    20
`define DUTY_INT_MAX    40
`define DUTY_LOW_MAX    60
`define DUTY_HIGH_MAX   80
`define DUTY_FLT1_MAX   95

// ==========================================================
// Sensitivity step that gives a wipe under internal fault
`define SENS_FLT_FROM   3'h3
`define SENS_FLT_TO     3'h2

// ==========================================================
// Timing
`define CLK_HZ          40000000
`define FAULT_CONFIRM_MS 1000
`define SENS_GAP_MS     2000
`define WIPE_MS         1000
`define INT_PAUSE_MS    3000
`define FRAME_US        1000

`endif

// file: src/rain_wiper_ctrl.v
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "wiper_map.vh"
// Behaviour
// - Stalk wiper selections arrive over LIN and are taken from those messages.
// - Manual off, mist, low, high, wash; automatic intermittent, low, high.
// - Rain sensor function enabled only while run ignition feed is on.
// - Ignition on and auto selected: both relays follow the rain sensor.
// - Ignition turning on with switch in auto gives exactly one single wipe.
// - Entering auto while sensor reports rain gives one single wipe.
// - Entering auto while sensor reports off gives no wipe, except first entry.
// - First entry into auto since ignition on always gives a single wipe.
// - In auto, raising sensitivity to a more sensitive step gives a wipe.
// - Sensitivity wipe only while sensor reports rain detected.
// - Several raises give one wipe; another only after over 2 s gap.
// - In auto, fault 1 duty code held 1 s confirms internal fault.
// - Confirmed internal fault switches all wiper relays off.
// - Under fault, one slow wipe on sensitivity 3 to 2 only.

module rain_wiper_ctrl #(
   parameter FRAME_CYC   = (`FRAME_US * (`CLK_HZ / 1000000)),
   parameter CONFIRM_CYC = (`FAULT_CONFIRM_MS * (`CLK_HZ / 1000)),
   parameter GAP_CYC     = (`SENS_GAP_MS * (`CLK_HZ / 1000)),
   parameter WIPE_CYC    = (`WIPE_MS * (`CLK_HZ / 1000)),
   parameter PAUSE_CYC   = (`INT_PAUSE_MS * (`CLK_HZ / 1000)),
   parameter CW          = 28
) (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_reset,
   // APB slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // Stalk switch, decoded from LIN frames
   input  wire [2:0]  i_lin_wiper_sel,
   input  wire        i_lin_wash,
   input  wire [2:0]  i_lin_sens,
   // Pins
   input  wire        i_run_ignition_feed,
   input  wire        i_rain_pwm,
   // Relays and interrupt
   output reg         o_relay_low,
   output reg         o_relay_high,
   output wire        o_irq
);

   // ==========================================================
   // States of the single wipe sequencer
   localparam [1:0] S_IDLE = 2'b01;
   localparam [1:0] S_WIPE = 2'b10;

   // ==========================================================
   // Duty classification
   function [2:0] classify;
      input [CW-1:0] hi;
      reg   [39:0]   h100;
      reg   [39:0]   f;
      begin
         h100 = {12'h000, hi} * 40'd100;
         f    = {8'h00, FRAME_CYC[31:0]};
         if (hi == {CW{1'b0}} || hi >= FRAME_CYC[CW-1:0])
            classify = `CODE_NONE;
         else if (h100 < f * `DUTY_OFF_MAX)
            classify = `CODE_OFF;
         else if (h100 < f * `DUTY_INT_MAX)
            classify = `CODE_RAIN_INT;
         else if (h100 < f * `DUTY_LOW_MAX)
            classify = `CODE_RAIN_LOW;
         else if (h100 < f * `DUTY_HIGH_MAX)
            classify = `CODE_RAIN_HIGH;
         else if (h100 <= f * `DUTY_FLT1_MAX)
            classify = `CODE_FAULT1;
         else
            classify = `CODE_NONE;
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   reg ign_s1_q;
   reg ign_s2_q;
   reg pwm_s1_q;
   reg pwm_s2_q;

   always @(posedge i_clk) begin
      if (i_reset) begin
         ign_s1_q <= 1'b0;
         ign_s2_q <= 1'b0;
         pwm_s1_q <= 1'b0;
         pwm_s2_q <= 1'b0;
      end else begin
         ign_s1_q <= i_run_ignition_feed;
         ign_s2_q <= ign_s1_q;
         pwm_s1_q <= i_rain_pwm;
         pwm_s2_q <= pwm_s1_q;
      end
   end

   // ==========================================================
   // Register state
   reg              ctrl_en_q;
   reg [`IRQ_W-1:0] irq_q;
   reg [`IRQ_W-1:0] mask_q;

   // ==========================================================
   // Rain sensor duty measurement
   reg [CW-1:0] frame_q;
   reg [CW-1:0] hi_q;
   reg [2:0]    code_q;

   always @(posedge i_clk) begin
      if (i_reset || !ign_s2_q) begin
         frame_q <= {CW{1'b0}};
         hi_q    <= {CW{1'b0}};
         code_q  <= `CODE_NONE;
      end else if (frame_q == FRAME_CYC[CW-1:0] - 1'b1) begin
         frame_q <= {CW{1'b0}};
         hi_q    <= {CW{1'b0}};
         code_q  <= classify(hi_q);
      end else begin
         frame_q <= frame_q + 1'b1;
         hi_q    <= hi_q + {{(CW-1){1'b0}}, pwm_s2_q};
      end
   end

   wire rain = (code_q == `CODE_RAIN_INT) || (code_q == `CODE_RAIN_LOW) ||
               (code_q == `CODE_RAIN_HIGH);

   // ==========================================================
   // Mode and edges
   reg       ign_d_q;
   reg       auto_d_q;
   reg [2:0] sens_d_q;
   reg       entered_q;

   wire auto_sel = (i_lin_wiper_sel == `SEL_AUTO);
   wire on       = ign_s2_q && ctrl_en_q;
   wire auto_on  = on && auto_sel;
   wire ign_rise = ign_s2_q && !ign_d_q;
   wire auto_ent = on && auto_sel && !auto_d_q && !ign_rise;
   wire sens_up  = auto_on && (i_lin_sens < sens_d_q);

   always @(posedge i_clk) begin
      if (i_reset) begin
         ign_d_q   <= 1'b0;
         auto_d_q  <= 1'b0;
         sens_d_q  <= 3'h0;
         entered_q <= 1'b0;
      end else begin
         ign_d_q  <= ign_s2_q;
         auto_d_q <= auto_sel;
         sens_d_q <= i_lin_sens;
         if (!ign_s2_q)
            entered_q <= 1'b0;
         else if ((ign_rise && auto_sel) || auto_ent)
            entered_q <= 1'b1;
      end
   end

   // ==========================================================
   // Internal fault confirmation
   reg [CW-1:0] fcnt_q;
   reg          fault_q;
   wire         flt_code = auto_on && (code_q == `CODE_FAULT1);

   always @(posedge i_clk) begin
      if (i_reset || !flt_code) begin
         fcnt_q  <= {CW{1'b0}};
         fault_q <= 1'b0;
      end else if (fcnt_q == CONFIRM_CYC[CW-1:0] - 1'b1) begin
         fault_q <= 1'b1;
      end else begin
         fcnt_q <= fcnt_q + 1'b1;
      end
   end

   reg  fault_d_q;
   wire fault_rise = fault_q && !fault_d_q;

   // ==========================================================
   // Sensitivity gap timer
   reg [CW-1:0] gap_q;
   wire         gap_done = (gap_q == {CW{1'b0}});

   always @(posedge i_clk) begin
      if (i_reset)
         gap_q <= {CW{1'b0}};
      else if (sens_up)
         gap_q <= GAP_CYC[CW-1:0];
      else if (!gap_done)
         gap_q <= gap_q - 1'b1;
   end

   // ==========================================================
   // Wipe requests
   reg  [1:0]    st_q;
   reg  [CW-1:0] pause_q;
   wire idle     = (st_q == S_IDLE);
   wire int_mode = auto_on && !fault_q && (code_q == `CODE_RAIN_INT);
   wire int_req  = int_mode && idle && (pause_q == PAUSE_CYC[CW-1:0]);
   wire w_ign    = on && ign_rise && auto_sel;
   wire w_ent    = auto_ent && !fault_q && (rain || !entered_q);
   wire w_sens   = sens_up && !fault_q && rain && gap_done;
   wire w_flt    = auto_on && fault_q && (sens_d_q == `SENS_FLT_FROM) &&
                   (i_lin_sens == `SENS_FLT_TO);
   wire wipe_req = w_ign || w_ent || w_sens || w_flt || int_req;

   always @(posedge i_clk) begin
      if (i_reset || !int_mode)
         pause_q <= {CW{1'b0}};
      else if (int_req)
         pause_q <= {CW{1'b0}};
      else if (idle && pause_q != PAUSE_CYC[CW-1:0])
         pause_q <= pause_q + 1'b1;
   end

   // ==========================================================
   // Single wipe sequencer
   reg [CW-1:0] wcnt_q;
   reg          wflt_q;

   always @(posedge i_clk) begin
      if (i_reset || !on) begin
         st_q   <= S_IDLE;
         wcnt_q <= {CW{1'b0}};
         wflt_q <= 1'b0;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (wipe_req) begin
                  st_q   <= S_WIPE;
                  wcnt_q <= WIPE_CYC[CW-1:0] - 1'b1;
                  wflt_q <= w_flt;
               end
            end
            S_WIPE: begin
               if (wcnt_q == {CW{1'b0}})
                  st_q <= S_IDLE;
               else
                  wcnt_q <= wcnt_q - 1'b1;
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   wire wipe_start = idle && wipe_req && on;

   // ==========================================================
   // Relay drive
   wire wiping = (st_q == S_WIPE) && (!fault_q || wflt_q);
   wire man_lo = (i_lin_wiper_sel == `SEL_MIST) ||
                 (i_lin_wiper_sel == `SEL_LOW) || i_lin_wash;
   wire man_hi = (i_lin_wiper_sel == `SEL_HIGH);
   wire aut_lo = auto_on && !fault_q &&
                 (code_q == `CODE_RAIN_LOW);
   wire aut_hi = auto_on && !fault_q &&
                 (code_q == `CODE_RAIN_HIGH);
   wire lo_d   = on && (wiping || aut_lo || (!auto_sel && man_lo) ||
                 (auto_sel && i_lin_wash && !fault_q));
   wire hi_d   = on && (aut_hi || (!auto_sel && man_hi));

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_relay_low  <= 1'b0;
         o_relay_high <= 1'b0;
         fault_d_q    <= 1'b0;
      end else begin
         o_relay_low  <= lo_d;
         o_relay_high <= hi_d;
         fault_d_q    <= fault_q;
      end
   end

   // ==========================================================
   // APB slave
   wire acc    = i_psel && i_penable;
   wire mapped = (i_paddr == `REG_CTRL) || (i_paddr == `REG_STATUS) ||
                 (i_paddr == `REG_IRQ_STAT) || (i_paddr == `REG_IRQ_MASK);
   wire rd_clr = acc && !i_pwrite && (i_paddr == `REG_IRQ_STAT);

   assign o_pready  = 1'b1;
   assign o_pslverr = acc && !mapped;

   wire [`IRQ_W-1:0] ev;
   assign ev[`IRQ_WIPE]   = wipe_start;
   assign ev[`IRQ_FAULT]  = fault_rise;
   assign ev[`IRQ_IGN_ON] = ign_rise;

   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h0000_0000;
      case (i_paddr)
         `REG_CTRL:     rd_d[0] = ctrl_en_q;
         `REG_STATUS:   rd_d = {22'h000000, st_q == S_WIPE, code_q,
                                o_relay_high, o_relay_low, entered_q,
                                auto_on, fault_q, ign_s2_q};
         `REG_IRQ_STAT: rd_d[`IRQ_W-1:0] = irq_q;
         `REG_IRQ_MASK: rd_d[`IRQ_W-1:0] = mask_q;
         default:       rd_d = 32'h0000_0000;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_en_q <= `CTRL_RESET;
         mask_q    <= `MASK_RESET;
         irq_q     <= {`IRQ_W{1'b0}};
         o_prdata  <= 32'h0000_0000;
      end else begin
         if (i_psel && !i_penable && !i_pwrite)
            o_prdata <= rd_d;
         if (acc && i_pwrite && i_paddr == `REG_CTRL)
            ctrl_en_q <= i_pwdata[`CTRL_ENABLE];
         if (acc && i_pwrite && i_paddr == `REG_IRQ_MASK)
            mask_q <= i_pwdata[`IRQ_W-1:0];
         // Set wins over read clear
         irq_q <= (rd_clr ? {`IRQ_W{1'b0}} : irq_q) | ev;
      end
   end

   assign o_irq = |(irq_q & mask_q);

endmodule // rain_wiper_ctrl

// file: verif/rain_sensor_model.sv
`timescale 1ns/1ps
// ==========
// Rain sensor duty-cycle source
module rain_sensor_model #(
   parameter FRAME = 100
) (
   // Clock
   input  wire       i_clk,
   // Duty in percent
   input  wire [6:0] i_duty,
   // Sensor pin
   output reg        o_pwm
);
   integer cnt = 0;
   initial o_pwm = 1'b0;
   always @(posedge i_clk) begin
      cnt   <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      o_pwm <= (cnt * 100) < (i_duty * FRAME);
   end
endmodule // rain_sensor_model

// file: verif/rain_wiper_ctrl_sva.sv
`timescale 1ns/1ps
`include "wiper_map.vh"
// ==========
// Port checks
module rain_wiper_ctrl_sva (
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pslverr,
   input wire logic [2:0]  i_lin_wiper_sel,
   input wire logic        i_lin_wash,
   input wire logic        i_run_ignition_feed,
   input wire logic        o_relay_low,
   input wire logic        o_relay_high
);
   wire       ign = i_run_ignition_feed;
   wire [2:0] sel = i_lin_wiper_sel;
   wire       acc = i_psel && i_penable;
   wire       hit = i_paddr == `REG_CTRL || i_paddr == `REG_STATUS ||
                    i_paddr == `REG_IRQ_STAT || i_paddr == `REG_IRQ_MASK;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ign_off_a:
   assert property ((!ign) [*6] |-> !o_relay_low && !o_relay_high) else $error("relay on");
   ign_wipe_a:
   assert property ($rose(ign) && sel == `SEL_AUTO ##1 (ign && sel == `SEL_AUTO) [*6]
      |-> o_relay_low) else $error("no wipe");
   man_low_a:
   assert property ((ign && sel == `SEL_LOW) [*6] |-> o_relay_low && !o_relay_high)
      else $error("low");
   man_high_a:
   assert property ((ign && sel == `SEL_HIGH) [*6] |-> o_relay_high) else $error("high");
   mist_low_a:
   assert property ((ign && sel == `SEL_MIST) [*6] |-> o_relay_low) else $error("mist");
   off_high_a:
   assert property ((sel == `SEL_OFF && !i_lin_wash) [*6] |-> !o_relay_high)
      else $error("off");
   bad_addr_a:
   assert property (acc && !hit |-> o_pslverr) else $error("err");
   bad_read_a:
   assert property (acc && !hit && !i_pwrite |-> o_prdata == 32'h0) else $error("rdata");
   good_addr_a:
   assert property (acc && hit |-> !o_pslverr) else $error("slverr");
endmodule // rain_wiper_ctrl_sva

// file: verif/rain_wiper_ctrl_tb.sv
`timescale 1ns/1ps
`include "wiper_map.vh"
// ==========
// Bench
module rain_wiper_ctrl_tb;
   localparam F  = 100;
   localparam WP = 20;
   reg         i_clk = 1'b0;
   reg         i_reset = 1'b1;
   reg         psel = 1'b0;
   reg         pen = 1'b0;
   reg         pwr = 1'b0;
   reg  [7:0]  pa = 8'h00;
   reg  [31:0] pwd = 32'h0;
   reg  [2:0]  sel = 3'h0;
   reg  [2:0]  sens = 3'h5;
   reg  [6:0]  duty = 7'h0A;
   reg         ign = 1'b0;
   reg         wash = 1'b0;
   wire [31:0] prd;
   wire        prdy, perr, pwm, rl, rh, irq;
   reg  [31:0] q;
   reg         e;
   integer     n, k, num_errors = 0, compares = 0;
   always #12.5 i_clk = ~i_clk;
   rain_wiper_ctrl #(.FRAME_CYC(F), .CONFIRM_CYC(200), .GAP_CYC(300), .WIPE_CYC(WP),
      .PAUSE_CYC(50)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
      .o_pready(prdy), .o_pslverr(perr), .i_lin_wiper_sel(sel), .i_lin_wash(wash),
      .i_lin_sens(sens), .i_run_ignition_feed(ign), .i_rain_pwm(pwm),
      .o_relay_low(rl), .o_relay_high(rh), .o_irq(irq));
   rain_sensor_model #(.FRAME(F)) i_sensor (.i_clk(i_clk), .i_duty(duty), .o_pwm(pwm));
   task close_out;
      begin
         if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge i_clk);
         psel <= 1'b1;
         pwr <= w;
         pa <= a;
         pwd <= d;
         @(posedge i_clk);
         pen <= 1'b1;
         n = 0;
         do begin
            @(posedge i_clk);
            n = n + 1;
         end while (prdy !== 1'b1 && n < 20);
         if (n == 20) begin
            num_errors = num_errors + 1;
            close_out;
         end
         q = prd;
         e = perr;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask
   task drv(input [2:0] s, input [2:0] sv, input [6:0] d, input g);
      begin
         @(posedge i_clk);
         sel <= s;
         sens <= sv;
         duty <= d;
         ign <= g;
      end
   endtask
   task seek(input v, input integer lim);
      begin
         n = 0;
         while (rl !== v && n < lim) begin
            @(negedge i_clk);
            n = n + 1;
         end
      end
   endtask
   task t_regs;
      begin
         apb(0, `REG_CTRL, 0);
         chk(q, 32'h1);
         apb(0, `REG_IRQ_MASK, 0);
         chk(q, 32'h0);
         apb(1, `REG_IRQ_MASK, 32'h7);
         apb(0, `REG_IRQ_MASK, 0);
         chk(q, 32'h7);
         apb(0, 8'h10, 0);
         chk({31'h0, e}, 32'h1);
         chk(q, 32'h0);
      end
   endtask
   task t_ign;
      begin
         drv(`SEL_AUTO, 3'h5, 7'h0A, 1'b0);
         repeat (20) @(negedge i_clk);
         chk({rh, rl}, 2'b00);
         drv(`SEL_AUTO, 3'h5, 7'h0A, 1'b1);
         seek(1'b1, 10);
         chk(n < 10, 1);
         chk(irq, 1);
         apb(0, `REG_IRQ_STAT, 0);
         chk(q[2:0], 3'h5);
         @(negedge i_clk);
         chk(irq, 0);
         seek(1'b0, 40);
         seek(1'b1, 3 * WP);
         chk(n, 3 * WP);
      end
   endtask
   task t_entry;
      begin
         drv(`SEL_OFF, 3'h5, 7'h0A, 1'b0);
         repeat (10) @(negedge i_clk);
         chk({rh, rl}, 2'b00);
         drv(`SEL_OFF, 3'h5, 7'h0A, 1'b1);
         repeat (2 * F) @(negedge i_clk);
         drv(`SEL_AUTO, 3'h5, 7'h0A, 1'b1);
         seek(1'b1, 10);
         chk(n < 10, 1);
         seek(1'b0, 40);
         drv(`SEL_OFF, 3'h5, 7'h0A, 1'b1);
         repeat (2 * F) @(negedge i_clk);
         drv(`SEL_AUTO, 3'h5, 7'h0A, 1'b1);
         seek(1'b1, F);
         chk(n, F);
         drv(`SEL_OFF, 3'h5, 7'h1E, 1'b1);
         repeat (3 * F) @(negedge i_clk);
         drv(`SEL_AUTO, 3'h5, 7'h1E, 1'b1);
         seek(1'b1, 10);
         chk(n < 10, 1);
      end
   endtask
   task t_sens;
      begin
         seek(1'b0, 60);
         drv(`SEL_AUTO, 3'h4, 7'h1E, 1'b1);
         seek(1'b1, 8);
         chk(n < 8, 1);
         seek(1'b0, 40);
         drv(`SEL_AUTO, 3'h3, 7'h1E, 1'b1);
         seek(1'b1, 8);
         chk(n, 8);
         seek(1'b1, 60);
         chk(n < 60, 1);
         drv(`SEL_OFF, 3'h3, 7'h0A, 1'b1);
         repeat (4 * F) @(negedge i_clk);
         drv(`SEL_AUTO, 3'h2, 7'h0A, 1'b1);
         seek(1'b1, 20);
         chk(n, 20);
         drv(`SEL_AUTO, 3'h2, 7'h32, 1'b1);
         repeat (3 * F) @(negedge i_clk);
         chk({rh, rl}, 2'b01);
         drv(`SEL_AUTO, 3'h2, 7'h46, 1'b1);
         repeat (3 * F) @(negedge i_clk);
         chk({rh, rl}, 2'b10);
      end
   endtask
   task t_manual;
      begin
         for (k = 3; k >= 0; k = k - 1) begin
            drv(k[2:0], 3'h2, 7'h0A, 1'b1);
            repeat (8) @(negedge i_clk);
            chk({rh, rl}, {k == 3, k == 1 || k == 2});
         end
         @(posedge i_clk);
         wash <= 1'b1;
         repeat (8) @(negedge i_clk);
         chk({rh, rl}, 2'b01);
         apb(1, `REG_CTRL, 32'h0);
         repeat (8) @(negedge i_clk);
         chk({rh, rl}, 2'b00);
         apb(1, `REG_CTRL, 32'h1);
         @(posedge i_clk);
         wash <= 1'b0;
      end
   endtask
   task t_fault;
      begin
         drv(`SEL_AUTO, 3'h3, 7'h5A, 1'b1);
         for (k = 0; k < 400 && !q[1]; k = k + 1) begin
            apb(0, `REG_STATUS, 0);
            repeat (50) @(negedge i_clk);
         end
         chk(q[1], 1);
         chk({rh, rl}, 2'b00);
         @(posedge i_clk);
         wash <= 1'b1;
         repeat (8) @(negedge i_clk);
         chk({rh, rl}, 2'b00);
         @(posedge i_clk);
         wash <= 1'b0;
         drv(`SEL_AUTO, 3'h2, 7'h5A, 1'b1);
         seek(1'b1, 10);
         chk(n < 10, 1);
         seek(1'b0, 40);
         drv(`SEL_AUTO, 3'h1, 7'h5A, 1'b1);
         seek(1'b1, 20);
         chk(n, 20);
      end
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      t_regs;
      t_ign;
      t_entry;
      t_sens;
      t_manual;
      t_fault;
      close_out;
   end
endmodule // rain_wiper_ctrl_tb
bind rain_wiper_ctrl rain_wiper_ctrl_sva i_sva (.i_clk(i_clk), .i_reset(i_reset),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .o_prdata(o_prdata),
   .o_pslverr(o_pslverr), .i_lin_wiper_sel(i_lin_wiper_sel), .i_lin_wash(i_lin_wash),
   .i_run_ignition_feed(i_run_ignition_feed), .o_relay_low(o_relay_low),
   .o_relay_high(o_relay_high));
